// file: rtl/rcsf_flag_calc.sv
/*
  Arithmetic flags of one 8-bit add or subtract, with decimal adjust for decimal adds.
  Assumes a purely combinational use; the caller registers the outputs.
*/
`timescale 1ns/1ns
module rcsf_flag_calc
  import rcsf_pkg::*;
(
  // operation
  input wire rcsf_alu_op_t op_i,
  // results
  output logic [7:0] result_o,
  output rcsf_flags_t flags_o
);

  logic [7:0] b_eff;
  logic [4:0] low;
  logic [8:0] sum;
  logic [8:0] tmp;
  logic [8:0] dec;
  logic c_into7;
  logic ovf;
  logic neg;
  logic dl;
  logic dh;

  always_comb begin
    b_eff = op_i.sub ? ~op_i.b : op_i.b;
    low = {1'b0, op_i.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, op_i.sub};
    sum = {1'b0, op_i.a} + {1'b0, b_eff} + {8'h00, op_i.sub};
    c_into7 = op_i.a[7] ^ b_eff[7] ^ sum[7];
    ovf = c_into7 ^ sum[8];
    neg = sum[7] ^ ovf;
    dl = low[4] | (sum[3:0] > 4'h9);
    tmp = sum + (dl ? 9'h006 : 9'h000);
    dh = sum[8] | tmp[8] | (tmp[7:4] > 4'h9);
    dec = {1'b0, tmp[7:0]} + (dh ? 9'h060 : 9'h000);
    flags_o.ovf = ovf;
    flags_o.nonneg = ~neg;
    flags_o.nonpos = neg | ((sum[7:0] == 8'h00) & ~ovf);
    if (op_i.decimal && !op_i.sub) begin
      result_o = dec[7:0];
      flags_o.carry = dh;
      flags_o.half = dl;
      flags_o.zero = (dec[7:0] == 8'h00);
    end else begin
      result_o = sum[7:0];
      flags_o.carry = sum[8];
      flags_o.half = low[4];
      flags_o.zero = (sum[7:0] == 8'h00);
    end
  end

endmodule : rcsf_flag_calc

// file: rtl/rcsf_pkg.sv
/*
  Package of the reset cause and status flag block: register indices, field positions,
  reset values, mode encodings and the structs carried between its modules.
  Assumes an 8-bit processor core and a 32-bit classic Wishbone register bus.
*/
package rcsf_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0] RCSF_IDX_CPU_CONTROL = 6'h0e;
  localparam logic [5:0] RCSF_IDX_PROC_STATUS = 6'h0f;
  localparam logic [5:0] RCSF_IDX_EVT_STATUS = 6'h10;
  localparam logic [5:0] RCSF_IDX_EVT_CLEAR = 6'h11;
  localparam logic [5:0] RCSF_IDX_EVT_ENABLE = 6'h12;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int RCSF_BIT_CARRY = 0;
  localparam int RCSF_BIT_HALF = 1;
  localparam int RCSF_BIT_ZERO = 2;
  localparam int RCSF_BIT_OVF = 3;
  localparam int RCSF_BIT_NONPOS = 4;
  localparam int RCSF_BIT_NONNEG = 5;
  localparam int RCSF_BIT_PD_N = 6;
  localparam int RCSF_BIT_TO_N = 7;
  localparam int RCSF_BIT_SPEED = 0;
  localparam int RCSF_BIT_DEPTH = 1;
  localparam int RCSF_EVT_OVF = 0;
  localparam int RCSF_EVT_SLEEP = 1;
  localparam int RCSF_EVT_IDLE = 2;
  localparam int RCSF_EVT_WAKE = 3;
  localparam int RCSF_EVT_NUM = 4;

  // ****************************************************************
  // reset values and counts
  // ****************************************************************
  localparam logic [5:0] RCSF_FLAGS_RST = 6'h00;
  localparam logic [1:0] RCSF_CAUSE_PIN = 2'h3;
  localparam logic [3:0] RCSF_EVT_RST = 4'h0;
  localparam logic [7:0] RCSF_BYTE_ZERO = 8'h00;
  localparam int RCSF_SYNC_STAGES = 2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    RCSF_MODE_SLOW = 2'b00,
    RCSF_MODE_FAST = 2'b01,
    RCSF_MODE_IDLE = 2'b10,
    RCSF_MODE_SLEEP = 2'b11
  } rcsf_mode_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic sub;
    logic decimal;
  } rcsf_alu_op_t;

  typedef struct packed {
    logic nonneg;
    logic nonpos;
    logic ovf;
    logic zero;
    logic half;
    logic carry;
  } rcsf_flags_t;

endpackage : rcsf_pkg

// file: rtl/rcsf_reset_sync.sv
/*
  Combines every reset source into one internal reset, asserted at once, released on clk.
  Assumes the sources are levels; the pin input is active low.
*/
`timescale 1ns/1ns
module rcsf_reset_sync
  import rcsf_pkg::*;
(
  // clock
  input wire logic clk_i,
  // sources
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic wdt_timeout_i,
  input wire logic ext_reset_n_pin_i,
  // internal reset
  output logic sys_rst_o
);

  logic [RCSF_SYNC_STAGES-1:0] stage_r;
  logic raw_rst;

  assign raw_rst = rst_i | por_i | wdt_timeout_i | ~ext_reset_n_pin_i;

  // set at once, released after two clean edges
  always_ff @(posedge clk_i or posedge raw_rst) begin
    if (raw_rst) begin
      stage_r <= '1;
    end else begin
      stage_r <= {stage_r[RCSF_SYNC_STAGES-2:0], 1'b0};
    end
  end

  assign sys_rst_o = stage_r[RCSF_SYNC_STAGES-1];

endmodule : rcsf_reset_sync

// file: rtl/rcsf_top.sv
/*
  Reset cause and processor status flag block: internal reset, status register with
  arithmetic flags and cause flags, cpu control register, operating mode and event irq.
  Assumes a classic Wishbone master, a core giving one-cycle instruction pulses.
*/
`timescale 1ns/1ns

// Behaviour
// - power-on detection, watchdog expiry or a low reset pin each reset the device.
// - the reset pin is active low, low holds reset and high releases it, with a pull-up.
// - bit 0 holds the add carry and for subtraction the inverse of the borrow.
// - bit 1 holds the half carry of the last result and bit 2 marks a zero result.
// - bit 3 is set when a signed operation carries into or borrows from the sign bit.
// - bit 4 is set for a signed hex result at or below zero, decimal ops keep it.
// - bit 5 is set for a signed hex result at or above zero, decimal ops keep it.
// - with overflow set, bit 5 marks overflow and bit 4 marks underflow.
// - the low-active power-down flag clears on sleep entry and sets on clear, power-on or pin.
// - the low-active time-out flag clears on watchdog reset and sets on clear, sleep, power-on, pin.
// - a reset restores every register except the two cause flags.
// - the cause pair reads 00 watchdog in sleep, 01 watchdog awake, 11 power-on or pin.
// - each reset reloads the speed-select bit from the initial-mode option.
// - with the option set to slow, execution starts in slow mode after any reset.
// - speed select one gives fast mode on the pll, zero slow mode on the slow oscillator.
// - the sleep instruction with sleep depth zero enters sleep and clears power-down.
module rcsf_top
  import rcsf_pkg::*;
(
  // clock and bus reset
  input wire logic clk_i,
  input wire logic rst_i,
  // reset sources and option
  input wire logic por_i,
  input wire logic wdt_timeout_i,
  input wire logic ext_reset_n_pin_i,
  input wire logic initial_mode_option_i,
  // core events
  input wire logic alu_upd_i,
  input wire rcsf_alu_op_t alu_op_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic sleep_instr_i,
  input wire logic wake_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // status and control outputs
  output logic sys_rst_o,
  output logic [7:0] status_o,
  output logic [7:0] alu_result_o,
  output logic speed_select_o,
  output logic sleep_depth_o,
  output rcsf_mode_t mode_o,
  output logic irq_o
);

  // ****************************************************************
  // internal reset
  // ****************************************************************
  logic sys_rst;
  logic sys_rst_r;

  rcsf_reset_sync u_reset_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .por_i(por_i),
    .wdt_timeout_i(wdt_timeout_i),
    .ext_reset_n_pin_i(ext_reset_n_pin_i),
    .sys_rst_o(sys_rst)
  );

  always_ff @(posedge clk_i) begin
    sys_rst_r <= sys_rst;
  end

  assign sys_rst_o = sys_rst_r;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic ack_r;
  logic [31:0] rdata_r;
  logic req;
  logic wr_en;
  logic [5:0] idx;
  logic lane0;

  assign req = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[7:2];
  assign lane0 = wb_sel_i[0];
  assign wr_en = req & wb_we_i & ack_r & lane0;

  // ****************************************************************
  // arithmetic flags
  // ****************************************************************
  rcsf_flags_t calc_flags;
  rcsf_flags_t flags_r;
  logic [7:0] calc_result;
  logic [7:0] result_r;

  rcsf_flag_calc u_flag_calc (
    .op_i(alu_op_i),
    .result_o(calc_result),
    .flags_o(calc_flags)
  );

  // hardware update wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      flags_r <= RCSF_FLAGS_RST;
      result_r <= RCSF_BYTE_ZERO;
    end else if (alu_upd_i) begin
      flags_r.carry <= calc_flags.carry;
      flags_r.half <= calc_flags.half;
      flags_r.zero <= calc_flags.zero;
      flags_r.ovf <= calc_flags.ovf;
      result_r <= calc_result;
      if (!alu_op_i.decimal) begin
        flags_r.nonpos <= calc_flags.nonpos;
        flags_r.nonneg <= calc_flags.nonneg;
      end
    end else if (wr_en && idx == RCSF_IDX_PROC_STATUS) begin
      flags_r <= wb_dat_i[5:0];
    end
  end

  // ****************************************************************
  // cause flags: never touched by the internal reset
  // ****************************************************************
  logic [1:0] cause_r;
  logic sleep_entry;
  logic running;

  assign running = (mode_o == RCSF_MODE_SLOW) || (mode_o == RCSF_MODE_FAST);
  assign sleep_entry = sleep_instr_i & ~sleep_depth_o & running & ~sys_rst;

  always_ff @(posedge clk_i) begin
    if (rst_i || por_i || !ext_reset_n_pin_i) begin
      cause_r <= RCSF_CAUSE_PIN;
    end else if (wdt_timeout_i) begin
      cause_r[1] <= 1'b0;
    end else if (watchdog_clear_instr_i) begin
      cause_r <= RCSF_CAUSE_PIN;
    end else if (sleep_entry) begin
      cause_r <= 2'b10;
    end
  end

  assign status_o = {cause_r, flags_r};
  assign alu_result_o = result_r;

  // ****************************************************************
  // cpu control register
  // ****************************************************************
  logic speed_r;
  logic depth_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      speed_r <= initial_mode_option_i;
      depth_r <= 1'b0;
    end else if (wr_en && idx == RCSF_IDX_CPU_CONTROL) begin
      speed_r <= wb_dat_i[RCSF_BIT_SPEED];
      depth_r <= wb_dat_i[RCSF_BIT_DEPTH];
    end
  end

  assign speed_select_o = speed_r;
  assign sleep_depth_o = depth_r;

  // ****************************************************************
  // operating mode
  // ****************************************************************
  rcsf_mode_t mode_r;
  rcsf_mode_t mode_nxt;

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      RCSF_MODE_SLOW, RCSF_MODE_FAST: begin
        if (sleep_instr_i) begin
          mode_nxt = depth_r ? RCSF_MODE_IDLE : RCSF_MODE_SLEEP;
        end else begin
          mode_nxt = speed_r ? RCSF_MODE_FAST : RCSF_MODE_SLOW;
        end
      end
      RCSF_MODE_IDLE, RCSF_MODE_SLEEP: begin
        if (wake_i) begin
          mode_nxt = speed_r ? RCSF_MODE_FAST : RCSF_MODE_SLOW;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      mode_r <= initial_mode_option_i ? RCSF_MODE_FAST : RCSF_MODE_SLOW;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  assign mode_o = mode_r;

  // ****************************************************************
  // event status, enable and interrupt
  // ****************************************************************
  logic [RCSF_EVT_NUM-1:0] evt;
  logic [RCSF_EVT_NUM-1:0] evt_sts_r;
  logic [RCSF_EVT_NUM-1:0] evt_en_r;
  logic [RCSF_EVT_NUM-1:0] evt_clr;
  logic irq_r;

  assign evt[RCSF_EVT_OVF] = alu_upd_i & calc_flags.ovf & ~sys_rst;
  assign evt[RCSF_EVT_SLEEP] = sleep_entry;
  assign evt[RCSF_EVT_IDLE] = sleep_instr_i & depth_r & running & ~sys_rst;
  assign evt[RCSF_EVT_WAKE] = wake_i & ~running & ~sys_rst;
  assign evt_clr = (wr_en && idx == RCSF_IDX_EVT_CLEAR) ? wb_dat_i[RCSF_EVT_NUM-1:0] : '0;

  // set wins over clear
  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      evt_sts_r <= RCSF_EVT_RST;
    end else begin
      evt_sts_r <= (evt_sts_r & ~evt_clr) | evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      evt_en_r <= RCSF_EVT_RST;
    end else if (wr_en && idx == RCSF_IDX_EVT_ENABLE) begin
      evt_en_r <= wb_dat_i[RCSF_EVT_NUM-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(evt_sts_r & evt_en_r);
    end
  end

  assign irq_o = irq_r;

  // ****************************************************************
  // bus answer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= '0;
    end else if (req && !ack_r) begin
      rdata_r <= '0;
      unique case (idx)
        RCSF_IDX_CPU_CONTROL: rdata_r[1:0] <= {depth_r, speed_r};
        RCSF_IDX_PROC_STATUS: rdata_r[7:0] <= {cause_r, flags_r};
        RCSF_IDX_EVT_STATUS: rdata_r[RCSF_EVT_NUM-1:0] <= evt_sts_r;
        RCSF_IDX_EVT_ENABLE: rdata_r[RCSF_EVT_NUM-1:0] <= evt_en_r;
        default: rdata_r <= '0;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_pin_reset;
    @(posedge clk_i) !ext_reset_n_pin_i |=> sys_rst;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin low did not reset");

  property p_src_reset;
    @(posedge clk_i) (por_i || wdt_timeout_i) |=> sys_rst;
  endproperty
  a_src_reset: assert property (p_src_reset) else $error("source did not reset");

  property p_release;
    @(posedge clk_i) $fell(sys_rst) |-> $past(!por_i && !wdt_timeout_i && ext_reset_n_pin_i, 2);
  endproperty
  a_release: assert property (p_release) else $error("reset released too early");

  property p_cause_pin;
    @(posedge clk_i) (por_i || !ext_reset_n_pin_i) |=> status_o[7:6] == 2'b11;
  endproperty
  a_cause_pin: assert property (p_cause_pin) else $error("cause not 11");

  property p_wdt_cause;
    @(posedge clk_i) disable iff (rst_i)
      (wdt_timeout_i && !por_i && ext_reset_n_pin_i)
      |=> !status_o[7] && $stable(status_o[6]);
  endproperty
  a_wdt_cause: assert property (p_wdt_cause) else $error("watchdog cause wrong");

  property p_sleep_pd;
    @(posedge clk_i) disable iff (rst_i)
      (sleep_entry && !por_i && ext_reset_n_pin_i && !wdt_timeout_i && !watchdog_clear_instr_i)
      |=> status_o[7:6] == 2'b10 ##1 (mode_o == RCSF_MODE_SLEEP || $past(wake_i || sys_rst));
  endproperty
  a_sleep_pd: assert property (p_sleep_pd) else $error("sleep entry flags wrong");

  property p_speed_reload;
    @(posedge clk_i) sys_rst |=> speed_select_o == $past(initial_mode_option_i);
  endproperty
  a_speed_reload: assert property (p_speed_reload) else $error("speed not reloaded");

  property p_reset_flags;
    @(posedge clk_i) sys_rst |=> status_o[5:0] == RCSF_FLAGS_RST && !sleep_depth_o;
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("flags not reset");

  property p_borrow;
    @(posedge clk_i) disable iff (sys_rst)
      (alu_upd_i && alu_op_i.sub && !alu_op_i.decimal && alu_op_i.a < alu_op_i.b)
      |=> !status_o[RCSF_BIT_CARRY];
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow not shown");

  property p_zero;
    @(posedge clk_i) disable iff (sys_rst)
      (alu_upd_i && !alu_op_i.decimal && !alu_op_i.sub && (alu_op_i.a == ~alu_op_i.b + 8'h01))
      |=> status_o[RCSF_BIT_ZERO];
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag missing");

  property p_decimal_keep;
    @(posedge clk_i) disable iff (sys_rst)
      (alu_upd_i && alu_op_i.decimal) |=> $stable(status_o[5:4]);
  endproperty
  a_decimal_keep: assert property (p_decimal_keep) else $error("decimal moved sign flags");

  property p_overflow_dir;
    @(posedge clk_i) disable iff (sys_rst)
      (status_o[RCSF_BIT_OVF] && status_o[RCSF_BIT_NONNEG] && $past(alu_upd_i)
       && !$past(alu_op_i.decimal)) |-> alu_result_o[7];
  endproperty
  a_overflow_dir: assert property (p_overflow_dir) else $error("overflow direction wrong");

  property p_fast;
    @(posedge clk_i) disable iff (sys_rst)
      (running && !sleep_instr_i && speed_select_o) |=> mode_o == RCSF_MODE_FAST;
  endproperty
  a_fast: assert property (p_fast) else $error("fast mode not taken");

  c_wdt_in_sleep: cover property (@(posedge clk_i) status_o[7:6] == 2'b00);
  c_wdt_awake: cover property (@(posedge clk_i) status_o[7:6] == 2'b01);
  c_overflow: cover property (@(posedge clk_i) status_o[RCSF_BIT_OVF] && status_o[RCSF_BIT_NONPOS]);
  c_irq: cover property (@(posedge clk_i) irq_o);

endmodule : rcsf_top

// file: test/rcsf_reset_src_model.sv
/*
  Model of the reset sources: power-on detector, watchdog expiry and the reset pin.
  Assumes one-cycle requests from the bench; each source is then held for HOLD cycles.
*/
`timescale 1ns/1ns
module rcsf_reset_src_model #(
  parameter int HOLD = 3
) (
  // clock
  input wire logic clk_i,
  // requests
  input wire logic por_req_i,
  input wire logic wdt_req_i,
  input wire logic pin_req_i,
  // sources
  output logic por_o,
  output logic wdt_timeout_o,
  output logic ext_reset_n_pin_o
);
  // ****************************************************************
  // hold counters
  // ****************************************************************
  logic [2:0] req;
  int cnt [3] = '{0, 0, 0};
  assign req = {pin_req_i, wdt_req_i, por_req_i};
  always @(posedge clk_i) begin
    for (int k = 0; k < 3; k++) begin
      if (req[k]) begin
        cnt[k] <= HOLD;
      end else if (cnt[k] > 0) begin
        cnt[k] <= cnt[k] - 1;
      end
    end
  end
  assign por_o = (cnt[0] > 0);
  assign wdt_timeout_o = (cnt[1] > 0);
  // pull-up keeps the pin high unless a reset is pressed
  assign ext_reset_n_pin_o = !(cnt[2] > 0);
endmodule : rcsf_reset_src_model

// file: test/test_reset_cause_and_status_flags.sv
/*
  Self-checking bench of the reset cause and status flag block.
  Assumes rcsf_pkg, the design and the reset source model are compiled first.
*/
`timescale 1ns/1ns
module test_reset_cause_and_status_flags;
  import rcsf_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic opt = 0;
  logic upd = 0;
  logic slp = 0;
  logic wclr = 0;
  logic wk = 0;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [2:0] req = 3'h0;
  rcsf_alu_op_t op = '0;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic ack, sys_rst, irq, spd, dep, por, wdt, pin_n;
  logic [7:0] st, res;
  rcsf_mode_t mode;
  logic [1:0] cause;
  logic [17:0] q [$];
  logic [31:0] rnd = 32'ha962;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  event ev;
  always #5 clk_i = ~clk_i;
  rcsf_reset_src_model #(.HOLD(3)) src (.clk_i(clk_i), .por_req_i(req[0]),
    .wdt_req_i(req[1]), .pin_req_i(req[2]), .por_o(por), .wdt_timeout_o(wdt),
    .ext_reset_n_pin_o(pin_n));
  rcsf_top DUT (.clk_i(clk_i), .rst_i(rst_i), .por_i(por), .wdt_timeout_i(wdt),
    .ext_reset_n_pin_i(pin_n), .initial_mode_option_i(opt), .alu_upd_i(upd),
    .alu_op_i(op), .watchdog_clear_instr_i(wclr), .sleep_instr_i(slp), .wake_i(wk),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .sys_rst_o(sys_rst),
    .status_o(st), .alu_result_o(res), .speed_select_o(spd), .sleep_depth_o(dep),
    .mode_o(mode), .irq_o(irq));
  // ****************************************************************
  // scoreboard
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input logic [7:0] m);
    n_checks++;
    if ((seen & m) !== (exp & m)) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic note(input logic [1:0] s, input logic [7:0] e, input logic [7:0] m = 8'hff);
    q.push_back({s, m, e});
    ->ev;
  endtask : note
  always @(ev) begin
    logic [17:0] e;
    while (q.size() > 0) begin
      e = q.pop_front();
      case (e[17:16])
        2'h0: check(st, e[7:0], e[15:8]);
        2'h1: check(rd[7:0], e[7:0], e[15:8]);
        2'h2: check(res, e[7:0], e[15:8]);
        default: check({dep, sys_rst, 2'h0, irq, spd, mode}, e[7:0], e[15:8]);
      endcase
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      $display("mismatch at %0t: run timed out", $time);
      complete_run();
    end
  end
  // ****************************************************************
  // drivers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // ack and read data are taken at the edge itself; only the run timeout ends a wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic settle();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while ((sys_rst !== 1'b0 || por || wdt || !pin_n) && n < 40);
    repeat (2) @(posedge clk_i);
    #1;
    note(2'h0, {cause, 6'h00});
    note(2'h3, {5'h0, opt, 1'b0, opt});
  endtask : settle
  task automatic reset_src(input int k);
    @(posedge clk_i);
    req[k] <= 1'b1;
    @(posedge clk_i);
    req[k] <= 1'b0;
    @(posedge clk_i);
    #1;
    note(2'h3, 8'h40, 8'h40);
    cause = (k == 1) ? {1'b0, cause[0]} : 2'b11;
    settle();
  endtask : reset_src
  task automatic pulse(input logic s);
    @(posedge clk_i);
    slp <= s;
    wclr <= !s;
    @(posedge clk_i);
    slp <= 1'b0;
    wclr <= 1'b0;
    #1;
  endtask : pulse
  task automatic chk_irq(input logic v);
    repeat (2) @(posedge clk_i);
    #1;
    note(2'h3, {4'h0, v, 3'h0}, 8'h08);
  endtask : chk_irq
  task automatic alu_run(input int n);
    logic [17:0] dir [4] = '{{8'h60, 8'h70, 2'b00}, {8'h50, 8'h90, 2'b10},
      {8'h00, 8'h00, 2'b00}, {8'h10, 8'h10, 2'b10}};
    logic [7:0] pe, pm, pr, nx, bb;
    logic [8:0] s9, t8;
    logic [4:0] t5;
    logic ov, ne, pd;
    rcsf_alu_op_t o;
    pe = {cause, 6'h00};
    pm = 8'hff;
    pr = 8'h00;
    pd = 1'b1;
    for (int i = 0; i <= n; i++) begin
      rnd = xs(rnd);
      o = (i < 4) ? dir[i] : rnd[17:0];
      bb = o.sub ? ~o.b : o.b;
      s9 = {1'b0, o.a} + {1'b0, bb} + o.sub;
      t5 = {1'b0, o.a[3:0]} + {1'b0, bb[3:0]} + o.sub;
      t8 = {2'b0, o.a[6:0]} + {2'b0, bb[6:0]} + o.sub;
      ov = t8[7] ^ s9[8];
      ne = s9[7] ^ ov;
      nx = {cause, o.decimal ? pe[5:4] : {!ne, ne | (s9[7:0] == 8'h00 && !ov)},
        ov, s9[7:0] == 8'h00, t5[4], s9[8]};
      @(posedge clk_i);
      upd <= (i < n);
      op <= o;
      #1;
      if (i > 0) begin
        note(2'h0, pe, pm);
      end
      if (i > 0 && !pd) begin
        note(2'h2, pr);
      end
      pe = nx;
      pm = (o.decimal && !o.sub) ? 8'hf0 : 8'hff;
      pr = s9[7:0];
      pd = o.decimal;
    end
  endtask : alu_run
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    cause = 2'b11;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    wb(1'b0, 8'h3c, 8'h00);
    note(2'h1, 8'hc0);
    wb(1'b1, 8'h80, 8'hff);
    wb(1'b0, 8'h80, 8'h00);
    note(2'h1, 8'h00);
    wb(1'b1, 8'h3c, 8'h3f);
    wb(1'b0, 8'h3c, 8'h00);
    note(2'h1, {cause, 6'h3f});
    $display("test reset and bus done");
    alu_run(60);
    $display("test flags done");
    wb(1'b1, 8'h38, 8'h01);
    @(posedge clk_i);
    #1;
    note(2'h3, 8'h05, 8'h07);
    wb(1'b1, 8'h38, 8'h00);
    wb(1'b1, 8'h48, 8'h02);
    pulse(1'b1);
    cause = 2'b10;
    note(2'h0, 8'h80, 8'hc0);
    note(2'h3, 8'h03, 8'h03);
    chk_irq(1'b1);
    wb(1'b0, 8'h40, 8'h00);
    note(2'h1, 8'h02, 8'h02);
    wb(1'b1, 8'h48, 8'h00);
    chk_irq(1'b0);
    wb(1'b1, 8'h48, 8'h02);
    chk_irq(1'b1);
    wb(1'b1, 8'h44, 8'h02);
    chk_irq(1'b0);
    @(posedge clk_i);
    wk <= 1'b1;
    @(posedge clk_i);
    wk <= 1'b0;
    #1;
    note(2'h3, 8'h00, 8'h03);
    wb(1'b1, 8'h38, 8'h02);
    pulse(1'b1);
    note(2'h0, 8'h80, 8'hc0);
    note(2'h3, 8'h82, 8'h83);
    wb(1'b0, 8'h40, 8'h00);
    note(2'h1, 8'h0d, 8'h0f);
    $display("test sleep and irq done");
    reset_src(1);
    reset_src(2);
    reset_src(1);
    pulse(1'b0);
    cause = 2'b11;
    note(2'h0, 8'hc0, 8'hc0);
    reset_src(1);
    reset_src(0);
    @(posedge clk_i);
    opt <= 1'b1;
    reset_src(2);
    @(posedge clk_i);
    opt <= 1'b0;
    reset_src(1);
    $display("test reset causes done");
    #1;
    complete_run();
  end
endmodule : test_reset_cause_and_status_flags
